// file: dcd_pkg.sv
// constants and types shared by the command decoder
// What this block does
// - chip select high acts exactly like no-op; nothing new starts
// - row strobe low alone opens the addressed row in the addressed bank
// - activate takes bank from both bank lines, row from address bits 0..11 or 0..12
// - column strobe low, write enable high starts a read burst
// - column strobe low, write enable low starts a write burst
// - column from address 0..9; address bit 10 selects auto precharge per access
// - precharge closes addressed bank, or all banks when address bit 10 high
// - refresh command: auto refresh if clock enable high, else self refresh entry
// - refresh uses internal row counter, ignores all inputs but clock enable and the write beat pins
// - mode load: bank lines 00 base register, 01 extended register, others reserved
// - mode load stores address bits 0..11 or 0..12 into selected register
// - write mask low writes the beat, high discards it
// - fet control output unsupported; extended register bit 2 stays zero
package dcd_pkg;
    localparam int BANKS       = 4;
    localparam int COL_BITS    = 10;
    localparam int AP_BIT      = 10;
    localparam int EMR_WIDTH   = 12;
    localparam int EMR_FET_BIT = 2;
    localparam logic [1:0] BANK_SEL_BASE = 2'h0;
    localparam logic [1:0] BANK_SEL_EXT  = 2'h1;
    localparam logic [EMR_WIDTH-1:0] EMR_RESET = 12'h000;

    // {row strobe, column strobe, write enable}, active low
    typedef enum logic [2:0] {
        DCD_CMD_MRS  = 3'b000,
        DCD_CMD_REF  = 3'b001,
        DCD_CMD_PRE  = 3'b010,
        DCD_CMD_ACT  = 3'b011,
        DCD_CMD_WR   = 3'b100,
        DCD_CMD_RD   = 3'b101,
        DCD_CMD_BST  = 3'b110,
        DCD_CMD_NOP  = 3'b111
    } dcd_cmd_t;

    typedef enum logic [1:0] {
        DCD_ST_IDLE  = 2'b00,
        DCD_ST_SELF  = 2'b01
    } dcd_state_t;
endpackage : dcd_pkg

// file: dcd_bank_table.sv
// per-bank open flag and open-row memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module dcd_bank_table
    import dcd_pkg::*;
#(
    parameter int ROW_BITS = 13
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    // updates
    input  wire logic                       open_en,
    input  wire logic                       close_en,
    input  wire logic                       close_all,
    input  wire logic [1:0]                 bank,
    input  wire logic [ROW_BITS-1:0]        row,
    // state
    output logic      [BANKS-1:0]           open_q,
    output logic      [ROW_BITS-1:0]        rd_row_q
);
    logic [ROW_BITS-1:0] rows_q [BANKS];
    logic [BANKS-1:0]    open_d;

    always_comb begin
        open_d = open_q;
        if (close_all) begin
            open_d = '0;
        end else if (close_en) begin
            open_d[bank] = 1'b0;
        end else if (open_en) begin
            open_d[bank] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            open_q   <= '0;
            rd_row_q <= '0;
        end else begin
            open_q   <= open_d;
            rd_row_q <= rows_q[bank];
        end
    end

    // storage has no reset; the open flags guard it
    always_ff @(posedge sys_clk) begin
        if (open_en) begin
            rows_q[bank] <= row;
        end
    end
endmodule : dcd_bank_table
`default_nettype wire

// file: dcd_decode.sv
// command decoder for one rank of double-data-rate memory
`timescale 1ns/100ps
`default_nettype none
module dcd_decode
    import dcd_pkg::*;
#(
    parameter int ROW_BITS = 13,
    parameter int REF_BITS = 13
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    // command pins
    input  wire logic                   clk_en,
    input  wire logic                   rank_select_n,
    input  wire logic                   row_strobe_n,
    input  wire logic                   col_strobe_n,
    input  wire logic                   write_en_n,
    input  wire logic                   bank_line_0,
    input  wire logic                   bank_line_1,
    input  wire logic [ROW_BITS-1:0]    addr,
    // write data beat
    input  wire logic                   beat_valid,
    input  wire logic                   write_mask,
    // decoded events
    output logic                        act_q,
    output logic                        rd_q,
    output logic                        wr_q,
    output logic                        bst_q,
    output logic                        pre_q,
    output logic                        auto_pre_q,
    output logic [1:0]                  bank_q,
    output logic [ROW_BITS-1:0]         row_q,
    output logic [COL_BITS-1:0]         col_q,
    output logic                        aref_q,
    output logic                        self_ref_q,
    output logic [REF_BITS-1:0]         ref_row_q,
    output logic                        beat_write_q,
    // mode registers and state
    output logic [ROW_BITS-1:0]         base_mode_q,
    output logic [EMR_WIDTH-1:0]        extended_mode_control_q,
    output logic                        fet_control_out_n,
    output logic [BANKS-1:0]            bank_open_q,
    output logic [ROW_BITS-1:0]         open_row_q
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic dcd_cmd_t decode(input logic ras, input logic cas, input logic we);
        decode = dcd_cmd_t'({ras, cas, we});
    endfunction : decode

    dcd_cmd_t cmd;
    logic     sel;
    logic [1:0] bank;
    assign cmd  = decode(row_strobe_n, col_strobe_n, write_en_n);
    assign sel  = !rank_select_n;
    assign bank = {bank_line_1, bank_line_0};

    dcd_state_t st_q, st_d;
    logic act_d, rd_d, wr_d, bst_d, pre_d, ap_d, aref_d, self_d, bw_d;
    logic [1:0]             bank_d;
    logic [ROW_BITS-1:0]    row_d, base_d;
    logic [COL_BITS-1:0]    col_d;
    logic [REF_BITS-1:0]    ref_d;
    logic [EMR_WIDTH-1:0]   emr_d;
    logic                   close_all;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d   = st_q;
        act_d  = 1'b0;
        rd_d   = 1'b0;
        wr_d   = 1'b0;
        bst_d  = 1'b0;
        pre_d  = 1'b0;
        aref_d = 1'b0;
        self_d = self_ref_q;
        ap_d   = auto_pre_q;
        bank_d = bank_q;
        row_d  = row_q;
        col_d  = col_q;
        ref_d  = ref_row_q;
        base_d = base_mode_q;
        emr_d  = extended_mode_control_q;
        close_all = 1'b0;
        bw_d   = beat_valid && !write_mask;
        unique case (st_q)
            DCD_ST_SELF: begin
                // only clock enable is looked at here
                if (clk_en) begin
                    st_d   = DCD_ST_IDLE;
                    self_d = 1'b0;
                end else begin
                    ref_d = ref_row_q + 1'b1;
                end
            end
            DCD_ST_IDLE: begin
                if (sel) begin
                    unique case (cmd)
                        DCD_CMD_ACT: begin
                            act_d  = 1'b1;
                            bank_d = bank;
                            row_d  = addr;
                        end
                        DCD_CMD_RD, DCD_CMD_WR: begin
                            rd_d   = (cmd == DCD_CMD_RD);
                            wr_d   = (cmd == DCD_CMD_WR);
                            bank_d = bank;
                            col_d  = addr[COL_BITS-1:0];
                            ap_d   = addr[AP_BIT];
                        end
                        DCD_CMD_BST: bst_d = 1'b1;
                        DCD_CMD_PRE: begin
                            pre_d     = 1'b1;
                            bank_d    = bank;
                            close_all = addr[AP_BIT];
                        end
                        DCD_CMD_REF: begin
                            ref_d = ref_row_q + 1'b1;
                            if (clk_en) begin
                                aref_d = 1'b1;
                            end else begin
                                self_d = 1'b1;
                                st_d   = DCD_ST_SELF;
                            end
                        end
                        DCD_CMD_MRS: begin
                            if (bank == BANK_SEL_BASE) begin
                                base_d = addr;
                            end else if (bank == BANK_SEL_EXT) begin
                                emr_d = addr[EMR_WIDTH-1:0];
                                emr_d[EMR_FET_BIT] = 1'b0;
                            end
                        end
                        DCD_CMD_NOP: ;
                    endcase
                end
            end
            default: st_d = DCD_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q                    <= DCD_ST_IDLE;
            act_q                   <= 1'b0;
            rd_q                    <= 1'b0;
            wr_q                    <= 1'b0;
            bst_q                   <= 1'b0;
            pre_q                   <= 1'b0;
            auto_pre_q              <= 1'b0;
            aref_q                  <= 1'b0;
            self_ref_q              <= 1'b0;
            bank_q                  <= '0;
            row_q                   <= '0;
            col_q                   <= '0;
            ref_row_q               <= '0;
            beat_write_q            <= 1'b0;
            base_mode_q             <= '0;
            extended_mode_control_q <= EMR_RESET;
            fet_control_out_n       <= 1'b1;
        end else begin
            st_q                    <= st_d;
            act_q                   <= act_d;
            rd_q                    <= rd_d;
            wr_q                    <= wr_d;
            bst_q                   <= bst_d;
            pre_q                   <= pre_d;
            auto_pre_q              <= ap_d;
            aref_q                  <= aref_d;
            self_ref_q              <= self_d;
            bank_q                  <= bank_d;
            row_q                   <= row_d;
            col_q                   <= col_d;
            ref_row_q               <= ref_d;
            beat_write_q            <= bw_d;
            base_mode_q             <= base_d;
            extended_mode_control_q <= emr_d;
            fet_control_out_n       <= 1'b1; // function not provided
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic cmd_open, cmd_close;
    assign cmd_open  = (st_q == DCD_ST_IDLE) && sel && (cmd == DCD_CMD_ACT);
    assign cmd_close = (st_q == DCD_ST_IDLE) && sel && (cmd == DCD_CMD_PRE);

    dcd_bank_table #(.ROW_BITS(ROW_BITS)) u_banks (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .open_en   (cmd_open),
        .close_en  (cmd_close),
        .close_all (cmd_close && close_all),
        .bank      (bank),
        .row       (addr),
        .open_q    (bank_open_q),
        .rd_row_q  (open_row_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    property p_deselect_idle;
        @(posedge sys_clk) disable iff (!nrst)
        (rank_select_n && st_q == DCD_ST_IDLE) |=> !(act_q || rd_q || wr_q || pre_q || aref_q);
    endproperty
    a_deselect_idle: assert property (p_deselect_idle) else $error("deselect started op");

    property p_act;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_ACT)
            |=> act_q && row_q == $past(addr) && bank_q == $past(bank);
    endproperty
    a_act: assert property (p_act) else $error("activate not decoded");

    property p_act_open;
        @(posedge sys_clk) disable iff (!nrst)
        act_q |-> bank_open_q[bank_q];
    endproperty
    a_act_open: assert property (p_act_open) else $error("bank not opened");

    property p_rd;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_RD) |=> rd_q && !wr_q;
    endproperty
    a_rd: assert property (p_rd) else $error("read not decoded");

    property p_wr;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_WR) |=> wr_q && !rd_q;
    endproperty
    a_wr: assert property (p_wr) else $error("write not decoded");

    property p_ap;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_q || wr_q) |-> auto_pre_q == $past(addr[AP_BIT]) && col_q == $past(addr[COL_BITS-1:0]);
    endproperty
    a_ap: assert property (p_ap) else $error("column or auto precharge wrong");

    property p_pre_all;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_PRE && addr[AP_BIT]) |=> bank_open_q == '0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left bank open");

    property p_self;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_REF && !clk_en) |=> self_ref_q && !aref_q;
    endproperty
    a_self: assert property (p_self) else $error("self refresh not entered");

    property p_self_ignore;
        @(posedge sys_clk) disable iff (!nrst)
        (self_ref_q && !clk_en) |=> $stable(extended_mode_control_q) && !act_q && !rd_q;
    endproperty
    a_self_ignore: assert property (p_self_ignore) else $error("input acted in refresh");

    property p_emr;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_MRS && bank == BANK_SEL_EXT)
            |=> extended_mode_control_q[1:0] == $past(addr[1:0]) && $stable(base_mode_q);
    endproperty
    a_emr: assert property (p_emr) else $error("extended load wrong");

    property p_fet;
        @(posedge sys_clk) disable iff (!nrst)
        !extended_mode_control_q[EMR_FET_BIT] && fet_control_out_n;
    endproperty
    a_fet: assert property (p_fet) else $error("fet control active");

    property p_mask;
        @(posedge sys_clk) disable iff (!nrst)
        (beat_valid && write_mask) |=> !beat_write_q;
    endproperty
    a_mask: assert property (p_mask) else $error("masked beat written");

    property p_beat;
        @(posedge sys_clk) disable iff (!nrst)
        (beat_valid && !write_mask) |=> beat_write_q;
    endproperty
    a_beat: assert property (p_beat) else $error("unmasked beat dropped");

    property p_pre_one;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_PRE && !addr[AP_BIT])
            |=> !bank_open_q[$past(bank)];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("addressed bank left open");

    property p_aref;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_REF && clk_en)
            |=> aref_q && !self_ref_q && ref_row_q == REF_BITS'($past(ref_row_q) + 1'b1);
    endproperty
    a_aref: assert property (p_aref) else $error("auto refresh not decoded");

    property p_self_exit;
        @(posedge sys_clk) disable iff (!nrst)
        (self_ref_q && clk_en) |=> !self_ref_q;
    endproperty
    a_self_exit: assert property (p_self_exit) else $error("self refresh not left");

    property p_base;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_MRS && bank == BANK_SEL_BASE)
            |=> base_mode_q == $past(addr) && $stable(extended_mode_control_q);
    endproperty
    a_base: assert property (p_base) else $error("base load wrong");

    property p_mrs_reserved;
        @(posedge sys_clk) disable iff (!nrst)
        (st_q == DCD_ST_IDLE && sel && cmd == DCD_CMD_MRS && bank[1])
            |=> $stable(base_mode_q) && $stable(extended_mode_control_q);
    endproperty
    a_mrs_reserved: assert property (p_mrs_reserved) else $error("reserved load acted");
endmodule : dcd_decode
`default_nettype wire

// file: dcd_ctrl_model.sv
// memory controller model that drives the decoder's command and beat pins
`timescale 1ns/100ps
`default_nettype none
module dcd_ctrl_model
    import dcd_pkg::*;
#(
    parameter int ROW_BITS = 13
) (
    // clock
    input  wire logic                sys_clk,
    // command pins
    output var  logic                clk_en,
    output var  logic                rank_select_n,
    output var  logic                row_strobe_n,
    output var  logic                col_strobe_n,
    output var  logic                write_en_n,
    output var  logic                bank_line_0,
    output var  logic                bank_line_1,
    output var  logic [ROW_BITS-1:0] addr,
    // write data beat
    output var  logic                beat_valid,
    output var  logic                write_mask
);
    initial begin
        clk_en = 1'b1;
        rank_select_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_en_n} = 3'h7;
        {bank_line_1, bank_line_0} = 2'h0;
        addr = '0;
        beat_valid = 1'b0;
        write_mask = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    // only codes of the command set can be passed in
    task automatic issue(input dcd_cmd_t cmd, input logic [1:0] bank,
                         input logic [ROW_BITS-1:0] a);
        rank_select_n = 1'b0;
        {row_strobe_n, col_strobe_n, write_en_n} = cmd;
        {bank_line_1, bank_line_0} = bank;
        addr = a;
        tick();
    endtask : issue

    // deselected lines keep changing so a stale value never looks valid
    task automatic idle();
        rank_select_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_en_n} = ~{row_strobe_n, col_strobe_n, write_en_n};
        {bank_line_1, bank_line_0} = ~{bank_line_1, bank_line_0};
        addr = ~addr;
        tick();
    endtask : idle

    task automatic set_cke(input logic v);
        clk_en = v;
    endtask : set_cke

    // data beats go out with the command lines deselected, so no command repeats
    task automatic beat(input logic v, input logic m);
        rank_select_n = 1'b1;
        beat_valid = v;
        write_mask = v ? m : ~write_mask;
        tick();
    endtask : beat
endmodule : dcd_ctrl_model
`default_nettype wire

// file: tb_dcd_decode.sv
// self-checking bench for the command decoder
`timescale 1ns/100ps
`default_nettype none
module tb_dcd_decode
    import dcd_pkg::*;
;
    localparam int ROW_BITS = 13;
    localparam int REF_BITS = 13;

    logic                sys_clk;
    logic                nrst;
    wire logic           clk_en, rank_select_n, row_strobe_n, col_strobe_n, write_en_n;
    wire logic           bank_line_0, bank_line_1, beat_valid, write_mask;
    wire logic [12:0]    addr;
    logic                act_q, rd_q, wr_q, bst_q, pre_q, auto_pre_q, aref_q, self_ref_q;
    logic                beat_write_q, fet_control_out_n;
    logic [1:0]          bank_q;
    logic [9:0]          col_q;
    logic [11:0]         extended_mode_control_q;
    logic [3:0]          bank_open_q;
    logic [12:0]         row_q, ref_row_q, base_mode_q, open_row_q, r0;
    wire logic [5:0]     pulses = {act_q, rd_q, wr_q, bst_q, pre_q, aref_q};
    int                  n_errors = 0;
    int                  total_checks = 0;

    dcd_decode #(.ROW_BITS(ROW_BITS), .REF_BITS(REF_BITS)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .rank_select_n(rank_select_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
        .bank_line_0(bank_line_0), .bank_line_1(bank_line_1), .addr(addr),
        .beat_valid(beat_valid), .write_mask(write_mask), .act_q(act_q), .rd_q(rd_q),
        .wr_q(wr_q), .bst_q(bst_q), .pre_q(pre_q), .auto_pre_q(auto_pre_q), .bank_q(bank_q),
        .row_q(row_q), .col_q(col_q), .aref_q(aref_q), .self_ref_q(self_ref_q),
        .ref_row_q(ref_row_q), .beat_write_q(beat_write_q), .base_mode_q(base_mode_q),
        .extended_mode_control_q(extended_mode_control_q),
        .fet_control_out_n(fet_control_out_n), .bank_open_q(bank_open_q),
        .open_row_q(open_row_q));

    dcd_ctrl_model #(.ROW_BITS(ROW_BITS)) u_ctrl (
        .sys_clk(sys_clk), .clk_en(clk_en), .rank_select_n(rank_select_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
        .bank_line_0(bank_line_0), .bank_line_1(bank_line_1), .addr(addr),
        .beat_valid(beat_valid), .write_mask(write_mask));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_vec

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t flag %s got %b", $time, what, got);
        end
    endtask : chk_bit

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk_vec(pulses, 16'h0, "pulses");
        chk_vec(bank_open_q, 16'h0, "open");
        chk_vec(extended_mode_control_q, EMR_RESET, "ext");
        chk_bit(fet_control_out_n, 1'b1, "fet");
    endtask : t_reset

    task automatic t_mode();
        u_ctrl.issue(DCD_CMD_MRS, BANK_SEL_BASE, 13'h1abc);
        chk_vec(base_mode_q, 16'h1abc, "base");
        // bit 2 set on purpose, it must not stick
        u_ctrl.issue(DCD_CMD_MRS, BANK_SEL_EXT, 13'h1006);
        chk_vec(extended_mode_control_q, 16'h002, "ext");
        u_ctrl.issue(DCD_CMD_MRS, 2'h2, 13'h0fff);
        u_ctrl.issue(DCD_CMD_MRS, 2'h3, 13'h0fff);
        chk_vec(base_mode_q, 16'h1abc, "base kept");
        chk_vec(extended_mode_control_q, 16'h002, "ext kept");
        u_ctrl.issue(DCD_CMD_MRS, BANK_SEL_EXT, 13'h0000);
        chk_vec(extended_mode_control_q, 16'h000, "ext");
        chk_bit(fet_control_out_n, 1'b1, "fet");
        repeat (200) u_ctrl.idle();
    endtask : t_mode

    task automatic t_act();
        for (int b = 0; b < BANKS; b++) begin
            u_ctrl.issue(DCD_CMD_ACT, 2'(b), 13'h1fff - 13'(b));
            chk_vec(pulses, 16'h20, "act");
            chk_vec(bank_q, 16'(b), "bank");
            chk_vec(row_q, 16'h1fff - 16'(b), "row");
            chk_vec(bank_open_q, 16'((1 << (b + 1)) - 1), "open");
        end
        for (int b = 0; b < BANKS; b++) begin
            u_ctrl.issue(DCD_CMD_NOP, 2'(b), 13'h0000);
            chk_vec(open_row_q, 16'h1fff - 16'(b), "stored row");
        end
    endtask : t_act

    task automatic t_rw();
        u_ctrl.issue(DCD_CMD_RD, 2'h1, 13'h1bff);
        chk_vec(pulses, 16'h10, "rd");
        chk_vec(col_q, 16'h3ff, "col");
        chk_bit(auto_pre_q, 1'b0, "ap");
        u_ctrl.issue(DCD_CMD_BST, 2'h3, 13'h0000);
        chk_vec(pulses, 16'h04, "bst");
        u_ctrl.issue(DCD_CMD_WR, 2'h2, 13'h0555);
        chk_vec(pulses, 16'h08, "wr");
        chk_vec(bank_q, 16'h2, "bank");
        chk_vec(col_q, 16'h155, "col");
        chk_bit(auto_pre_q, 1'b1, "ap");
        u_ctrl.beat(1'b1, 1'b0);
        chk_bit(beat_write_q, 1'b1, "beat");
        u_ctrl.beat(1'b1, 1'b1);
        chk_bit(beat_write_q, 1'b0, "masked");
        u_ctrl.beat(1'b0, 1'b0);
        chk_bit(beat_write_q, 1'b0, "no beat");
    endtask : t_rw

    task automatic t_pre();
        u_ctrl.issue(DCD_CMD_PRE, 2'h2, 13'h1bff);
        chk_vec(pulses, 16'h02, "pre");
        chk_vec(bank_open_q, 16'hb, "one bank");
        u_ctrl.issue(DCD_CMD_PRE, 2'h1, 13'h0400);
        chk_vec(bank_open_q, 16'h0, "all banks");
        u_ctrl.issue(DCD_CMD_ACT, 2'h0, 13'h0042);
        for (int i = 0; i < 4; i++) begin
            u_ctrl.idle();
            chk_vec(pulses, 16'h0, "deselect");
        end
        u_ctrl.issue(DCD_CMD_NOP, 2'h3, 13'h1fff);
        chk_vec(pulses, 16'h0, "nop");
        chk_vec(bank_open_q, 16'h1, "open");
        chk_vec(row_q, 16'h0042, "row");
    endtask : t_pre

    task automatic t_refresh();
        r0 = ref_row_q;
        u_ctrl.issue(DCD_CMD_REF, 2'h3, 13'h1fff);
        chk_vec(pulses, 16'h01, "aref");
        chk_vec(ref_row_q, 16'(r0 + 13'h1), "count");
        chk_vec(row_q, 16'h0042, "row");
        u_ctrl.set_cke(1'b0);
        u_ctrl.issue(DCD_CMD_REF, 2'h2, 13'h0000);
        chk_bit(self_ref_q, 1'b1, "self");
        u_ctrl.issue(DCD_CMD_ACT, 2'h2, 13'h0123);
        chk_vec(pulses, 16'h0, "ignored act");
        u_ctrl.issue(DCD_CMD_WR, 2'h1, 13'h0000);
        chk_vec(pulses, 16'h0, "ignored wr");
        u_ctrl.idle();
        chk_vec(ref_row_q, 16'(r0 + 13'h5), "count");
        chk_vec(bank_open_q, 16'h1, "open");
        u_ctrl.set_cke(1'b1);
        u_ctrl.idle();
        u_ctrl.idle();
        chk_bit(self_ref_q, 1'b0, "exit");
    endtask : t_refresh

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_reset();
        t_mode();
        t_act();
        t_rw();
        t_pre();
        t_refresh();
        conclude();
    end

    // the sequence needs under 400 cycles
    initial begin
        #20000;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end
endmodule : tb_dcd_decode
`default_nettype wire
